// File: eet_pkg.sv
// package: register map, field positions and reset values of the external event timer
package eet_pkg;

  // ==========================================================================
  // bus geometry
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned CNT_W     = 24;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;  // timer_control_status_register
  localparam logic [7:0] OFF_RELOAD      = 8'h04;  // reload_count_register
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h08;  // sticky event bits, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h0C;  // same layout as status
  localparam logic [7:0] OFF_COUNT       = 8'h10;  // live counter, read only

  // ==========================================================================
  // control/status field positions
  localparam int unsigned BIT_ENABLE  = 0;   // timer_enable_bit
  localparam int unsigned BIT_IRQ_EN  = 1;   // irq_enable_bit
  localparam int unsigned BIT_INVERT  = 2;   // polarity_invert_bit
  localparam int unsigned BIT_MODE_LO = 3;   // mode_select_field, three bits
  localparam int unsigned BIT_GPIO    = 6;   // general-purpose pin enable
  localparam int unsigned BIT_DONE    = 7;   // count_done_flag, read only
  localparam int unsigned BIT_DIR     = 8;   // pin_direction_bit, 1 = output
  localparam int unsigned BIT_DIN     = 9;   // pin input value, read only
  localparam int unsigned BIT_DOUT    = 10;  // pin_output_value_bit

  // writable bits of the control word; reserved bits 11..23 read zero
  localparam logic [CNT_W-1:0] CTRL_WR_MASK = 24'h00_057F;

  // ==========================================================================
  // mode codes and constants
  localparam logic [2:0] MODE_EXT_DOWN = 3'b111;   // external-clock down count
  localparam logic [2:0] MODE_GPIO     = 3'b000;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hFF_FFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;

  // interrupt status bits
  localparam int unsigned IRQ_BIT_DONE = 0;
  localparam logic [DATA_W-1:0] IRQ_IMPL_MASK = 32'h0000_0001;

  // ==========================================================================
  // reset values
  localparam logic [CNT_W-1:0]  RST_CTRL     = 24'h00_0000;
  localparam logic [CNT_W-1:0]  RST_RELOAD   = 24'h00_0000;
  localparam logic [DATA_W-1:0] RST_IRQ_MASK = 32'h0000_0000;
  localparam logic [15:0]       IRQ_VECTOR   = 16'h003C;  // program address of the timer vector

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: eet_sync.sv
// two-flop synchroniser for the asynchronous timer pin input
`timescale 1ns/1ps
module eet_sync
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;

  // ==========================================================================
  // first stage only feeds the second; pin idles high after reset (input bit resets set)
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // eet_sync

// File: eet_timer.sv
// external event timer/counter with axi4-lite register slave
// ============================================================================
// Summary of operation
// - mode 111 with enable set loads the counter from the reload register and starts counting.
// - each rising pin edge (invert clear) or falling pin edge (invert set) decrements the counter.
// - the counted edge after the counter reached zero sets the done flag and interrupts only if enabled.
// - after completion the counter reloads and counting repeats until enable is cleared.
// - in the processor wait state counting and interrupt delivery continue unchanged.
// - in the processor stop state counting halts and pin changes are ignored.
// - reload zero with a non-zero counter counts 2^24 events, interrupts, then interrupts every event.
// - reload zero with a zero counter interrupts on every counted event.
// - zero written to reload while running is loaded when the current count completes.
// - control word 000140 selects pin output with level low; later output-bit writes drive the pin.
// - control word 00002A selects period mode with interrupt enable but no counting, even with enable; only mode 111 counts.
// - the completion interrupt vectors to program address 3C.
// - the done flag clears on a control/status read, on interrupt acknowledge and on reset.
// - in pin output mode the output bit drives the pin, inverted by invert; ignored otherwise.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module eet_timer
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       soft_reset,
  input  wire logic                       cpu_stop,
  input  wire logic                       cpu_wait,
  input  wire logic                       irq_ack,
  input  wire logic [eet_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [eet_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [eet_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [eet_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       timer_io_in,
  output logic                            timer_io_out,
  output logic                            timer_io_oe,
  output logic                            timer_irq_req,
  output logic [15:0]                     timer_irq_vector,
  output logic                            irq
);
  import eet_pkg::*;
  // ==========================================================================
  // state
  logic [CNT_W-1:0]  ctrl_reg;
  logic [CNT_W-1:0]  reload_reg;
  logic [CNT_W-1:0]  count_reg;
  logic              done_reg;
  logic [DATA_W-1:0] irq_status_reg;
  logic [DATA_W-1:0] irq_mask_reg;
  logic              pin_prev_reg;
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              pin_sync;
  // ==========================================================================
  // pin input synchroniser
  eet_sync u_sync
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (timer_io_in),
    .sync_out (pin_sync)
  );
  // ==========================================================================
  // control field decode
  wire       te_bit     = ctrl_reg[BIT_ENABLE];
  wire       tie_bit    = ctrl_reg[BIT_IRQ_EN];
  wire       inv_bit    = ctrl_reg[BIT_INVERT];
  wire [2:0] mode_bits  = ctrl_reg[BIT_MODE_LO +: 3];
  wire       running    = te_bit && (mode_bits == MODE_EXT_DOWN);
  wire       gpio_on    = ctrl_reg[BIT_GPIO] && (mode_bits == MODE_GPIO);
  wire       gpio_out   = gpio_on && ctrl_reg[BIT_DIR];
  // ==========================================================================
  // axi write path decode
  wire               wr_fire     = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [7:0]         wr_off      = aw_addr_reg[7:0];
  wire               wr_ctrl     = wr_fire && (wr_off == OFF_CTRL_STATUS);
  wire               wr_reload   = wr_fire && (wr_off == OFF_RELOAD);
  wire               wr_istat    = wr_fire && (wr_off == OFF_IRQ_STATUS);
  wire               wr_imask    = wr_fire && (wr_off == OFF_IRQ_MASK);
  wire               wr_mapped   = wr_ctrl || wr_reload || wr_istat || wr_imask ||
                                   (wr_off == OFF_COUNT);
  wire [DATA_W-1:0]  wr_bytemask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                                    {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  // merged 24-bit words under byte enables
  wire [CNT_W-1:0] ctrl_merged   = (ctrl_reg & ~wr_bytemask[CNT_W-1:0]) |
                                   (w_data_reg[CNT_W-1:0] & wr_bytemask[CNT_W-1:0]);
  wire [CNT_W-1:0] reload_merged = (reload_reg & ~wr_bytemask[CNT_W-1:0]) |
                                   (w_data_reg[CNT_W-1:0] & wr_bytemask[CNT_W-1:0]);
  // output-bit writes only land when the new word selects gpio
  wire             new_gpio      = ctrl_merged[BIT_GPIO] && (ctrl_merged[BIT_MODE_LO +: 3] == MODE_GPIO);
  wire [CNT_W-1:0] ctrl_written  = new_gpio ? (ctrl_merged & CTRL_WR_MASK)
                                            : ((ctrl_merged & CTRL_WR_MASK & ~(24'h00_0001 << BIT_DOUT)) |
                                               (ctrl_reg & (24'h00_0001 << BIT_DOUT)));
  wire             new_running   = ctrl_written[BIT_ENABLE] &&
                                   (ctrl_written[BIT_MODE_LO +: 3] == MODE_EXT_DOWN);
  wire             start         = wr_ctrl && new_running && !running;
  // ==========================================================================
  // axi read path decode
  wire             rd_fire   = s_axi_arvalid && s_axi_arready;
  wire [7:0]       rd_off    = s_axi_araddr[7:0];
  wire             rd_ctrl   = rd_fire && (rd_off == OFF_CTRL_STATUS);
  wire             din_bit   = pin_sync ^ inv_bit;
  wire [CNT_W-1:0] ctrl_view = ctrl_reg | ({{(CNT_W-1){1'b0}}, done_reg} << BIT_DONE) |
                               ({{(CNT_W-1){1'b0}}, din_bit} << BIT_DIN);
  wire             rd_mapped = (rd_off == OFF_CTRL_STATUS) || (rd_off == OFF_RELOAD) ||
                               (rd_off == OFF_IRQ_STATUS) || (rd_off == OFF_IRQ_MASK) ||
                               (rd_off == OFF_COUNT);
  wire [DATA_W-1:0] rd_mux   = (rd_off == OFF_CTRL_STATUS) ? {8'h00, ctrl_view}  :
                               (rd_off == OFF_RELOAD)      ? {8'h00, reload_reg} :
                               (rd_off == OFF_IRQ_STATUS)  ? irq_status_reg      :
                               (rd_off == OFF_IRQ_MASK)    ? irq_mask_reg        :
                               (rd_off == OFF_COUNT)       ? {8'h00, count_reg}  : 32'h0000_0000;
  // ==========================================================================
  // edge selection; stop gates edges while history keeps tracking, so a stopped change never counts
  wire pin_rise  = pin_sync && !pin_prev_reg;
  wire pin_fall  = !pin_sync && pin_prev_reg;
  wire sel_edge  = inv_bit ? pin_fall : pin_rise;
  wire cnt_edge  = running && sel_edge && !cpu_stop;
  wire done_evt  = cnt_edge && !start && (count_reg == CNT_ZERO);
  wire done_clr  = rd_ctrl || irq_ack;
  wire [CNT_W-1:0] start_val = ((reload_reg == CNT_ZERO) && (count_reg != CNT_ZERO)) ? CNT_MAX
                                                                                      : reload_reg;
  // ==========================================================================
  // axi handshakes: address and data taken in any order, answer when both held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  // read channel: one outstanding read, data one cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ==========================================================================
  // control and reload registers; soft reset acts like hardware reset here
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset)
    begin
      ctrl_reg     <= RST_CTRL;
      reload_reg   <= RST_RELOAD;
      irq_mask_reg <= RST_IRQ_MASK;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= ctrl_written;
      if (wr_reload)
        reload_reg <= reload_merged;
      if (wr_imask)
        irq_mask_reg <= (w_data_reg & wr_bytemask) & IRQ_IMPL_MASK;
    end
  end
  // ==========================================================================
  // down counter: zero reload with a live count pre-sets all ones for 2^24 edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset)
      count_reg <= CNT_ZERO;
    else if (start)
      count_reg <= start_val;
    else if (done_evt)
      count_reg <= reload_reg;
    else if (cnt_edge)
      count_reg <= count_reg - 24'h00_0001;
  end
  // pin history keeps sampling even while stopped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_prev_reg <= 1'b1;
    else
      pin_prev_reg <= pin_sync;
  end
  // ==========================================================================
  // done flag and sticky interrupt status; a set beats a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset)
    begin
      done_reg       <= 1'b0;
      irq_status_reg <= 32'h0000_0000;
    end
    else
    begin
      if (done_evt)
        done_reg <= 1'b1;
      else if (done_clr)
        done_reg <= 1'b0;
      irq_status_reg[IRQ_BIT_DONE] <= (done_evt && tie_bit) ||
                                      (irq_status_reg[IRQ_BIT_DONE] &&
                                       !(wr_istat && w_strb_reg[0] && w_data_reg[IRQ_BIT_DONE]));
    end
  end
  // ==========================================================================
  // registered outputs: pin drive, core interrupt request, vector, bus irq
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_io_out     <= 1'b0;
      timer_io_oe      <= 1'b0;
      timer_irq_req    <= 1'b0;
      timer_irq_vector <= IRQ_VECTOR;
      irq              <= 1'b0;
    end
    else
    begin
      timer_io_out     <= ctrl_reg[BIT_DOUT] ^ inv_bit;
      timer_io_oe      <= gpio_out;
      timer_irq_req    <= done_reg && tie_bit;
      timer_irq_vector <= IRQ_VECTOR;
      irq              <= |(irq_status_reg & irq_mask_reg);
    end
  end
  // ==========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || soft_reset);
  sequence s_armed;
    start && (reload_reg != CNT_ZERO);
  endsequence
  property p_load_on_start;
    s_armed |=> (count_reg == $past(reload_reg));
  endproperty
  a_load_on_start: assert property (p_load_on_start) else $error("start did not load reload value");
  property p_decrement;
    cnt_edge && !start && (count_reg != CNT_ZERO) |=> (count_reg == $past(count_reg) - 24'h00_0001);
  endproperty
  a_decrement: assert property (p_decrement) else $error("counted edge did not decrement");
  property p_done_sets_flag;
    done_evt |=> done_reg;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag) else $error("done flag not set on completion");
  property p_req_needs_enable;
    !tie_bit |=> !timer_irq_req;
  endproperty
  a_req_needs_enable: assert property (p_req_needs_enable) else $error("request without irq enable");
  property p_reload_after_done;
    done_evt |=> (count_reg == $past(reload_reg));
  endproperty
  a_reload_after_done: assert property (p_reload_after_done) else $error("no reload after completion");
  property p_wait_counts;
    cpu_wait && !cpu_stop && running && sel_edge && !start && (count_reg != CNT_ZERO) |=> $changed(count_reg);
  endproperty
  a_wait_counts: assert property (p_wait_counts) else $error("counting stalled in wait state");
  property p_stop_freezes;
    cpu_stop && !start |=> $stable(count_reg) && !$rose(done_reg);
  endproperty
  a_stop_freezes: assert property (p_stop_freezes) else $error("counter moved in stop state");
  property p_zero_every_edge;
    cnt_edge && !start && (count_reg == CNT_ZERO) && (reload_reg == CNT_ZERO) |=> done_reg && (count_reg == CNT_ZERO);
  endproperty
  a_zero_every_edge: assert property (p_zero_every_edge) else $error("zero reload missed an event");
  property p_read_clears;
    rd_ctrl && !done_evt |=> !done_reg;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read left done flag set");
  property p_pin_follows;
    1'b1 |=> (timer_io_oe == $past(gpio_out)) && (timer_io_out == $past(ctrl_reg[BIT_DOUT] ^ inv_bit));
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pin drive does not follow output bit");
  property p_vector;
    timer_irq_req |-> (timer_irq_vector == IRQ_VECTOR);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong interrupt vector");
endmodule // eet_timer

// File: eet_pin_src.sv
// pin source model: the external signal that drives the timer pin
`timescale 1ns/1ps
module eet_pin_src
(
  input  wire logic aclk,
  output logic      pin
);
  // ==========================================================================
  // level changes
  // the pin idles high, the level the synchroniser assumes after reset, so no
  // false edge follows reset; each level is held six cycles so the two sync
  // flops and the edge detector see every change, since a shorter glitch would be lost
  initial pin = 1'b1;

  task automatic tog();
    @(posedge aclk);
    pin <= ~pin;
    repeat (5) @(posedge aclk);
  endtask

  // n full pulses give n rising and n falling edges
  task automatic pulses(input int n);
    repeat (2 * n) tog();
  endtask
endmodule // eet_pin_src

// File: test_external_event_timer_counter.sv
// self-checking testbench of the external event timer
`timescale 1ns/1ps
module test_external_event_timer_counter;
  import eet_pkg::*;
  // ==========================================================================
  // signals
  logic              aclk, aresetn, soft_reset, cpu_stop, cpu_wait, irq_ack;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              timer_io_in, timer_io_out, timer_io_oe, timer_irq_req, irq;
  logic [15:0]       timer_irq_vector;
  int                n_fail, n_compared, cyc;

  eet_timer i_dut (.aclk, .aresetn, .soft_reset, .cpu_stop, .cpu_wait, .irq_ack, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_io_in, .timer_io_out, .timer_io_oe, .timer_irq_req, .timer_irq_vector, .irq);
  eet_pin_src i_src (.aclk(aclk), .pin(timer_io_in));

  // ==========================================================================
  // clock and hang guard; the 20000-cycle ceiling is tens of times the expected run
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // ==========================================================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic a_ok;
    logic w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(a_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) a_ok = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_ok = 1'b1;
      s_axi_awvalid <= !a_ok;
      s_axi_wvalid  <= !w_ok;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rd_data, exp);
  endtask

  // ==========================================================================
  // scenarios
  // four counted edges from reload 3: done only on the edge after zero
  task automatic t_count();
    wr(OFF_IRQ_MASK, 32'h0000_0001);
    chk(32'(wr_resp), 32'(RESP_OKAY));
    wr(OFF_RELOAD, 32'h0000_0003);
    wr(OFF_CTRL_STATUS, 32'h0000_003B);
    i_src.pulses(3);
    rd(OFF_COUNT, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    i_src.pulses(1);
    repeat (5) @(posedge aclk);
    chk(32'(irq), 32'h0000_0001);
    chk(32'(timer_irq_vector), 32'h0000_003C);
    rd(OFF_COUNT, 32'h0000_0003);
    rd(OFF_CTRL_STATUS, 32'h0000_02BB);
    rd(OFF_CTRL_STATUS, 32'h0000_023B);
    wr(OFF_IRQ_STATUS, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0000_0000);
  endtask

  // stop freezes counting, wait does not
  task automatic t_power();
    cpu_stop <= 1'b1;
    i_src.pulses(2);
    cpu_stop <= 1'b0;
    rd(OFF_COUNT, 32'h0000_0003);
    cpu_wait <= 1'b1;
    i_src.pulses(2);
    cpu_wait <= 1'b0;
    rd(OFF_COUNT, 32'h0000_0001);
  endtask

  // zero reload while running, then one completion per event; acknowledge clears the request
  task automatic t_zero();
    wr(OFF_RELOAD, 32'h0000_0000);
    i_src.pulses(2);
    rd(OFF_IRQ_STATUS, 32'h0000_0001);
    wr(OFF_IRQ_STATUS, 32'h0000_0001);
    i_src.pulses(1);
    rd(OFF_IRQ_STATUS, 32'h0000_0001);
    chk(32'(timer_irq_req), 32'h0000_0001);
    @(posedge aclk);
    irq_ack <= 1'b1;
    @(posedge aclk);
    irq_ack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(timer_irq_req), 32'h0000_0000);
  endtask

  // inverted polarity: only the falling edge counts; zero reload on a held count preloads full scale
  task automatic t_invert();
    wr(OFF_CTRL_STATUS, 32'h0000_0000);
    wr(OFF_RELOAD, 32'h0000_0005);
    wr(OFF_CTRL_STATUS, 32'h0000_003F);
    i_src.tog();
    rd(OFF_COUNT, 32'h0000_0004);
    i_src.tog();
    rd(OFF_COUNT, 32'h0000_0004);
    wr(OFF_CTRL_STATUS, 32'h0000_0000);
    wr(OFF_RELOAD, 32'h0000_0000);
    wr(OFF_CTRL_STATUS, 32'h0000_003B);
    rd(OFF_COUNT, 32'h00FF_FFFF);
  endtask

  // pin output, period mode without enable, soft reset
  task automatic t_misc();
    wr(OFF_CTRL_STATUS, 32'h0000_0140);
    repeat (2) @(posedge aclk);
    chk({30'h0, timer_io_oe, timer_io_out}, 32'h0000_0002);
    wr(OFF_CTRL_STATUS, 32'h0000_0540);
    repeat (2) @(posedge aclk);
    chk(32'(timer_io_out), 32'h0000_0001);
    wr(OFF_CTRL_STATUS, 32'h0000_0544);
    repeat (2) @(posedge aclk);
    chk(32'(timer_io_out), 32'h0000_0000);
    wr(OFF_CTRL_STATUS, 32'h0000_0178);
    repeat (2) @(posedge aclk);
    chk(32'(timer_io_oe), 32'h0000_0000);
    wr(OFF_IRQ_STATUS, 32'h0000_0001);
    wr(OFF_CTRL_STATUS, 32'h0000_002A);
    i_src.pulses(2);
    rd(OFF_CTRL_STATUS, 32'h0000_062A);
    rd(OFF_IRQ_STATUS, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    chk(32'(rd_resp), 32'(RESP_SLVERR));
    wr(8'h14, 32'h0000_0001);
    chk(32'(wr_resp), 32'(RESP_SLVERR));
    wr(OFF_RELOAD, 32'h0012_3456);
    s_axi_wstrb <= 4'h2;
    wr(OFF_RELOAD, 32'h00FF_FF00);
    s_axi_wstrb <= 4'hF;
    rd(OFF_RELOAD, 32'h0012_FF56);
    @(posedge aclk);
    soft_reset <= 1'b1;
    @(posedge aclk);
    soft_reset <= 1'b0;
    rd(OFF_RELOAD, 32'h0000_0000);
    rd(OFF_CTRL_STATUS, 32'h0000_0200);
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    {aresetn, soft_reset, cpu_stop, cpu_wait, irq_ack} = 5'b00000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00000;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h0000_0000;
    s_axi_wstrb  = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CTRL_STATUS, 32'h0000_0200);
    rd(OFF_IRQ_MASK, 32'h0000_0000);
    t_count();
    t_power();
    t_zero();
    t_invert();
    t_misc();
    finish_test();
  end
endmodule // test_external_event_timer_counter
